// *** hdl/pin_sync3.sv ***
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Pin is asynchronous to sys_clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3
  import radio_pwr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output wire logic level_out
);

  sync_s s_reg;
  sync_s s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.ff = {s_reg.ff[1:0], pin_in};
    // First stage feeds only the second; filter looks at stages two and three
    if (s_reg.ff[1] == s_reg.ff[2]) begin
      s_next.q = s_reg.ff[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.q;

endmodule : pin_sync3

// *** hdl/radio_power_mode_control.sv ***
// Purpose: Transceiver power-mode control with regulator sequencing over AXI4-Lite
// Assumes: Pins vreg_ok_pin, vio_low_pin, select_low_pin are asynchronous
// Notes:   fifo_empty comes from logic on sys_clk
`timescale 1ns/1ps
`include "radio_pwr_map.svh"
module radio_power_mode_control
  import radio_pwr_pkg::*;
#(
  parameter logic [15:0] WAKE_INIT_CYCLES = `RPM_WAKE_INIT_CYCLES
)(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        vreg_ok_pin,
  input  wire logic        vio_low_pin,
  input  wire logic        select_low_pin,
  input  wire logic        fifo_empty,
  output wire logic        vreg_en,
  output wire logic        core_supply_en,
  output wire logic        xtal_en,
  output wire logic        reference_en,
  output wire logic        synth_en,
  output wire logic        synth_tx_freq,
  output wire logic        rx_chain_en,
  output wire logic        tx_chain_en,
  output wire logic        lpo_en,
  output wire logic        fifo_access_en,
  output wire logic        fifo_flush,
  output wire logic        ready_out,
  output wire logic        irq
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic domain_s mode_dom(input logic [3:0] code);
    domain_s d;
    d = '0;
    case (code)
      // RULE16 standby domains
      `RPM_MODE_STANDBY: begin
        d.core = 1'b1;
        d.xtal = 1'b1;
        d.refr = 1'b1;
      end
      // RULE17 FIFO mode domains
      `RPM_MODE_FIFO: begin
        d.core = 1'b1;
        d.refr = 1'b1;
        d.fifo = 1'b1;
      end
      `RPM_MODE_SYNTH_RX, `RPM_MODE_FULL_RX: begin
        d.core  = 1'b1;
        d.xtal  = 1'b1;
        d.refr  = 1'b1;
        d.synth = 1'b1;
        d.rx    = (code == `RPM_MODE_FULL_RX);
        d.fifo  = (code == `RPM_MODE_FULL_RX);
      end
      `RPM_MODE_SYNTH_TX, `RPM_MODE_FULL_TX: begin
        d.core     = 1'b1;
        d.xtal     = 1'b1;
        d.refr     = 1'b1;
        d.synth    = 1'b1;
        d.synth_tx = 1'b1;
        d.tx       = (code == `RPM_MODE_FULL_TX);
        d.fifo     = (code == `RPM_MODE_FULL_TX);
      end
      `RPM_MODE_WOR: begin
        d.lpo = 1'b1;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : mode_dom

  function automatic logic mode_legal(input logic [3:0] code);
    case (code)
      `RPM_MODE_OFF, `RPM_MODE_DEEP, `RPM_MODE_STANDBY, `RPM_MODE_FIFO,
      `RPM_MODE_SYNTH_RX, `RPM_MODE_FULL_RX, `RPM_MODE_WOR,
      `RPM_MODE_SYNTH_TX, `RPM_MODE_FULL_TX: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mode_legal

  // Power-down, standby and wake-on-radio lose the FIFO: wait for it to drain, then flush
  function automatic logic mode_drops_fifo(input logic [3:0] code);
    return (code == `RPM_MODE_OFF) || (code == `RPM_MODE_STANDBY) ||
           (code == `RPM_MODE_WOR);
  endfunction : mode_drops_fifo

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins_raw;
  logic [2:0] pins_sync;
  logic       regs_ok;
  logic       vio_low;
  logic       wake_req;

  assign pins_raw = {select_low_pin, vio_low_pin, vreg_ok_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      pin_sync3 u_sync (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (pins_raw[gi]),
        .level_out (pins_sync[gi])
      );
    end
  endgenerate

  assign regs_ok  = pins_sync[0];
  assign vio_low  = pins_sync[1];
  assign wake_req = ~pins_sync[2];

  // ---------------------------------------------------------------
  // State update
  // ---------------------------------------------------------------
  ctrl_s s_reg;
  ctrl_s s_next;

  always_comb begin
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [3:0] tgt;
    domain_s    d;
    irq_set = '0;
    irq_clr = '0;
    tgt     = s_reg.mode_req;
    d       = mode_dom(s_reg.mode_req);
    s_next  = s_reg;
    s_next.fifo_flush = 1'b0;
    s_next.ok_q       = regs_ok;
    s_next.bo_q       = vio_low;
    s_next.wake_q     = wake_req;
    if (regs_ok && !s_reg.ok_q) begin
      irq_set[`RPM_IRQ_REG_OK] = 1'b1;
    end
    if (vio_low && !s_reg.bo_q) begin
      irq_set[`RPM_IRQ_BROWNOUT] = 1'b1;
    end

    // Bus write channels, taken in either order
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = 2'h0;
      case (s_reg.aw_addr)
        `RPM_OFS_MODE: begin
          // Deep-sleeping transceiver ignores mode writes until wake-up completes
          if (s_reg.w_strb[0] && s_reg.st != st_deep && s_reg.st != st_wake) begin
            // RULE19 reserved code refused
            if (mode_legal(s_reg.w_data[3:0])) begin
              s_next.mode_req = s_reg.w_data[3:0];
              s_next.st       = st_sequence;
            end else begin
              irq_set[`RPM_IRQ_RESERVED] = 1'b1;
            end
          end
        end
        `RPM_OFS_STATUS: begin
          s_next.bresp = 2'h0;
        end
        `RPM_OFS_IRQ_STAT: begin
          if (s_reg.w_strb[0]) begin
            irq_clr = s_reg.w_data[3:0];
          end
        end
        `RPM_OFS_IRQ_MASK: begin
          if (s_reg.w_strb[0]) begin
            s_next.irq_mask = s_reg.w_data[3:0];
          end
        end
        default: begin
          s_next.bresp = 2'h2;
        end
      endcase
    end

    // Bus read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = '0;
      case (s_axi_araddr)
        `RPM_OFS_MODE: begin
          s_next.rdata[3:0] = s_reg.mode_req;
        end
        `RPM_OFS_STATUS: begin
          // RULE11 regulators ready bit
          s_next.rdata[`RPM_ST_REG_OK] = regs_ok;
          // RULE12 brown-out bit
          s_next.rdata[`RPM_ST_BROWNOUT] = vio_low;
          s_next.rdata[`RPM_ST_MODE_LSB +: 4] = s_reg.mode_cur;
          s_next.rdata[`RPM_ST_BUSY] = (s_reg.st == st_sequence) || (s_reg.st == st_wake);
          s_next.rdata[`RPM_ST_DEEP] = (s_reg.st == st_deep);
        end
        `RPM_OFS_IRQ_STAT: begin
          s_next.rdata[3:0] = s_reg.irq_stat;
        end
        `RPM_OFS_IRQ_MASK: begin
          s_next.rdata[3:0] = s_reg.irq_mask;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end

    // Set wins over a same-cycle clear
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;

    // Mode sequencer
    case (s_reg.st)
      st_settled: begin
        s_next.vreg_en = s_reg.dom.core;
      end
      st_sequence: begin
        if (tgt == `RPM_MODE_DEEP) begin
          // RULE14 everything off, state lost
          s_next.st       = st_deep;
          s_next.dom      = '0;
          s_next.vreg_en  = 1'b0;
          s_next.mode_cur = `RPM_MODE_DEEP;
          s_next.irq_stat = '0;
          s_next.irq_mask = '0;
          s_next.fifo_flush = 1'b1;
        end else if (mode_drops_fifo(tgt) && !fifo_empty) begin
          // RULE15 hold until FIFO drained
          s_next.st = st_sequence;
        end else if (d.core && (!regs_ok || !s_reg.vreg_en)) begin
          // RULE10 raise regulators before applying
          s_next.vreg_en = 1'b1;
        end else begin
          // RULE1 RULE2 RULE3 RULE4 RULE5 domain enables
          s_next.dom      = d;
          s_next.mode_cur = tgt;
          s_next.vreg_en  = d.core;
          s_next.st       = st_settled;
          // RULE13 discard FIFO on entering power-down, standby or wake-on-radio
          s_next.fifo_flush = mode_drops_fifo(tgt);
          s_next.irq_stat[`RPM_IRQ_APPLIED] = 1'b1;
        end
      end
      st_deep: begin
        if (wake_req && !s_reg.wake_q) begin
          s_next.st       = st_wake;
          s_next.init_cnt = '0;
        end
      end
      st_wake: begin
        s_next.init_cnt = s_reg.init_cnt + 16'h0001;
        if (s_reg.init_cnt == WAKE_INIT_CYCLES - 16'h0001) begin
          s_next.st       = st_settled;
          // Power-down after wake: FIFO content is gone
          s_next.fifo_flush = 1'b1;
          s_next.mode_req = `RPM_MODE_RESET;
          s_next.mode_cur = `RPM_MODE_RESET;
        end
      end
      default: begin
        s_next.st = st_settled;
      end
    endcase

    s_next.awready   = !s_next.aw_held;
    s_next.wready    = !s_next.w_held;
    s_next.arready   = !s_next.rvalid;
    s_next.ready_out = (s_next.st != st_deep) && (s_next.st != st_wake);
    s_next.irq       = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready  = s_reg.awready;
  assign s_axi_wready   = s_reg.wready;
  assign s_axi_bvalid   = s_reg.bvalid;
  assign s_axi_bresp    = s_reg.bresp;
  assign s_axi_arready  = s_reg.arready;
  assign s_axi_rvalid   = s_reg.rvalid;
  assign s_axi_rdata    = s_reg.rdata;
  assign s_axi_rresp    = 2'h0;
  assign vreg_en        = s_reg.vreg_en;
  assign core_supply_en = s_reg.dom.core;
  assign xtal_en        = s_reg.dom.xtal;
  assign reference_en   = s_reg.dom.refr;
  assign synth_en       = s_reg.dom.synth;
  assign synth_tx_freq  = s_reg.dom.synth_tx;
  assign rx_chain_en    = s_reg.dom.rx;
  assign tx_chain_en    = s_reg.dom.tx;
  assign lpo_en         = s_reg.dom.lpo;
  assign fifo_access_en = s_reg.dom.fifo;
  assign fifo_flush     = s_reg.fifo_flush;
  assign ready_out      = s_reg.ready_out;
  assign irq            = s_reg.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_synth_rx_only: assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    (s_reg.mode_cur == `RPM_MODE_SYNTH_RX && s_reg.st != st_deep)
      |-> (s_reg.dom.synth && !s_reg.dom.synth_tx && !s_reg.dom.rx && !s_reg.dom.tx))
    else $error("synth receive mode drives wrong domains");

  a_full_rx_on: assert property (@(posedge sys_clk) disable iff (reset) // RULE2
    $changed(s_reg.mode_cur) && s_reg.mode_cur == `RPM_MODE_FULL_RX
      |-> s_reg.dom.synth && s_reg.dom.rx && !s_reg.dom.tx)
    else $error("full receive mode without synth and receiver");

  a_wor_lpo_only: assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    s_reg.mode_cur == `RPM_MODE_WOR && s_reg.st == st_settled
      |-> s_reg.dom.lpo && !s_reg.dom.core && !s_reg.dom.fifo)
    else $error("wake-on-radio mode not power-down plus oscillator");

  a_synth_tx_only: assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    s_reg.mode_cur == `RPM_MODE_SYNTH_TX && s_reg.st != st_deep
      |-> s_reg.dom.synth_tx && s_reg.dom.synth && !s_reg.dom.tx && !s_reg.dom.rx)
    else $error("synth transmit mode drives wrong domains");

  a_full_tx_on: assert property (@(posedge sys_clk) disable iff (reset) // RULE5
    $rose(s_reg.dom.tx) |-> s_reg.mode_cur == `RPM_MODE_FULL_TX && s_reg.dom.synth_tx)
    else $error("transmitter on outside full transmit mode");

  a_core_needs_reg: assert property (@(posedge sys_clk) disable iff (reset) // RULE10
    $rose(s_reg.dom.core) |-> $past(regs_ok) && $past(s_reg.vreg_en) && s_reg.vreg_en)
    else $error("core domain on before regulators ready");

  a_status_ready: assert property (@(posedge sys_clk) disable iff (reset) // RULE11
    s_axi_arvalid && s_reg.arready && s_axi_araddr == `RPM_OFS_STATUS
      |=> s_reg.rvalid && s_reg.rdata[`RPM_ST_REG_OK] == $past(regs_ok))
    else $error("status ready bit does not follow regulators");

  a_status_brown: assert property (@(posedge sys_clk) disable iff (reset) // RULE12
    s_axi_arvalid && s_reg.arready && s_axi_araddr == `RPM_OFS_STATUS
      |=> s_reg.rdata[`RPM_ST_BROWNOUT] == $past(vio_low))
    else $error("status brown-out bit does not follow supply");

  a_off_flushes: assert property (@(posedge sys_clk) disable iff (reset) // RULE13
    $changed(s_reg.mode_cur) && s_reg.mode_cur == `RPM_MODE_OFF
      |-> s_reg.fifo_flush && !s_reg.dom.fifo && !s_reg.dom.core ##1 !s_reg.fifo_flush)
    else $error("power-down entry without one-cycle FIFO flush");

  a_deep_all_off: assert property (@(posedge sys_clk) disable iff (reset) // RULE14
    s_reg.st == st_deep |-> s_reg.dom == '0 && !s_reg.vreg_en && s_reg.irq_mask == '0)
    else $error("deep sleep leaves something powered or kept");

  a_off_fifo_empty: assert property (@(posedge sys_clk) disable iff (reset) // RULE15
    $changed(s_reg.mode_cur) && mode_drops_fifo(s_reg.mode_cur) |-> $past(fifo_empty))
    else $error("FIFO-losing mode entered with FIFO not empty");

  a_standby_doms: assert property (@(posedge sys_clk) disable iff (reset) // RULE16
    s_reg.mode_cur == `RPM_MODE_STANDBY
      |-> s_reg.dom.xtal && s_reg.dom.refr && !s_reg.dom.fifo && !s_reg.dom.rx)
    else $error("standby domains wrong");

  a_fifo_mode: assert property (@(posedge sys_clk) disable iff (reset) // RULE17
    s_reg.mode_cur == `RPM_MODE_FIFO |-> s_reg.dom.refr && s_reg.dom.fifo && !s_reg.fifo_flush)
    else $error("FIFO mode blocks or flushes FIFO");

  a_reserved_kept: assert property (@(posedge sys_clk) disable iff (reset) // RULE19
    s_reg.aw_held && s_reg.w_held && !s_reg.bvalid && s_reg.aw_addr == `RPM_OFS_MODE
      && !mode_legal(s_reg.w_data[3:0])
      |=> s_reg.mode_req == $past(s_reg.mode_req))
    else $error("reserved mode code accepted");

endmodule : radio_power_mode_control

// *** hdl/radio_pwr_map.svh ***
// Purpose: Offsets, field positions, mode codes and counts of the radio power-mode control
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   Operation summary below, one line per item
//
// Operation
// RULE1 - Code 1000 runs only the synthesizer on receive frequency, radio chains off
// RULE2 - Code 1001 runs synthesizer and receiver chain
// RULE3 - Code 1011 is power-down plus the 640 Hz low-power oscillator
// RULE4 - Code 1100 runs only the synthesizer on transmit frequency, radio chains off
// RULE5 - Code 1101 runs synthesizer and transmitter
// RULE6 - Controller enters full transmit only after synthesizer settles in synth-transmit
// RULE7 - Transmit session: power-down, standby, full transmit, power-down
// RULE8 - Controller waits crystal settling, typically 3 ms, after standby
// RULE9 - Receive session: power-down, standby, full receive, power-down
// RULE10 - Writing a mode sequences the regulators automatically
// RULE11 - Readable status bit shows regulated supplies ready
// RULE12 - Readable status bit shows I/O supply below 1.3 V brown-out
// RULE13 - Power-down: core supplies off, registers kept, FIFO blocked and discarded
// RULE14 - Deep-sleep: all supplies and functions off, all register values lost
// RULE15 - Code 0000 is power-down, entered only once the FIFO is empty
// RULE16 - Code 0101 is standby: crystal and reference on, FIFO inaccessible
// RULE17 - Code 0110 is FIFO mode: reference on, FIFO accessible and kept
// RULE18 - Controller leaves deep-sleep by select low, then polls ready high
// RULE19 - Unassigned mode codes are reserved and never taken
`ifndef RADIO_PWR_MAP_SVH
`define RADIO_PWR_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RPM_OFS_MODE      12'h000
`define RPM_OFS_STATUS    12'h004
`define RPM_OFS_IRQ_STAT  12'h008
`define RPM_OFS_IRQ_MASK  12'h00c

// ---------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------
`define RPM_MODE_OFF      4'h0
`define RPM_MODE_DEEP     4'h1
`define RPM_MODE_STANDBY  4'h5
`define RPM_MODE_FIFO     4'h6
`define RPM_MODE_SYNTH_RX 4'h8
`define RPM_MODE_FULL_RX  4'h9
`define RPM_MODE_WOR      4'hb
`define RPM_MODE_SYNTH_TX 4'hc
`define RPM_MODE_FULL_TX  4'hd
`define RPM_MODE_RESET    4'h0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RPM_ST_REG_OK     0
`define RPM_ST_BROWNOUT   1
`define RPM_ST_MODE_LSB   4
`define RPM_ST_BUSY       8
`define RPM_ST_DEEP       9
`define RPM_IRQ_REG_OK    0
`define RPM_IRQ_BROWNOUT  1
`define RPM_IRQ_APPLIED   2
`define RPM_IRQ_RESERVED  3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RPM_LPO_HZ           640
`define RPM_WAKE_INIT_CYCLES 16'h0010

`endif

// *** hdl/radio_pwr_pkg.sv ***
// Purpose: Types of the radio power-mode control
// Assumes: Constants live in radio_pwr_map.svh
// Notes:   One packed struct holds all state of each module
package radio_pwr_pkg;

  typedef enum logic [1:0] {st_settled, st_sequence, st_deep, st_wake} ctrl_state_e;

  typedef struct packed {
    logic core;
    logic xtal;
    logic refr;
    logic synth;
    logic synth_tx;
    logic rx;
    logic tx;
    logic lpo;
    logic fifo;
  } domain_s;

  typedef struct packed {
    ctrl_state_e st;
    logic [3:0]  mode_req;
    logic [3:0]  mode_cur;
    domain_s     dom;
    logic        vreg_en;
    logic        fifo_flush;
    logic        ready_out;
    logic        ok_q;
    logic        bo_q;
    logic        wake_q;
    logic [15:0] init_cnt;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        irq;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] ff;
    logic       q;
  } sync_s;

endpackage : radio_pwr_pkg

// *** verification/radio_power_mode_control_tb.sv ***
// Purpose: Self-checking bench of radio_power_mode_control
// Assumes: Supply model answers vreg_en after a short ramp
// Notes:   Wake count cut to 8 to keep the run short
`timescale 1ns/1ps
`include "radio_pwr_map.svh"
module radio_power_mode_control_tb;
  logic        sys_clk, reset, awvalid, wvalid, bready, arvalid, rready, awready;
  logic        wready, bvalid, arready, rvalid, irq, vreg_en, vreg_ok, vio_low;
  logic        sel_low, fifo_empty, fifo_flush, ready_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0]  bresp, resp, rresp;
  logic [8:0]  dom;
  logic [3:0]  seq [11] = '{4'h5, 4'hc, 4'hd, 4'h0, 4'h5, 4'h8, 4'h9, 4'h0, 4'h6, 4'hb, 4'h0};
  int          n_mismatch, compares;

  radio_power_mode_control #(.WAKE_INIT_CYCLES(16'h0008)) dut (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vreg_ok_pin(vreg_ok), .vio_low_pin(vio_low), .select_low_pin(sel_low),
    .fifo_empty(fifo_empty), .vreg_en(vreg_en), .core_supply_en(dom[8]), .xtal_en(dom[7]),
    .reference_en(dom[6]), .synth_en(dom[5]), .synth_tx_freq(dom[4]), .rx_chain_en(dom[3]),
    .tx_chain_en(dom[2]), .lpo_en(dom[1]), .fifo_access_en(dom[0]),
    .fifo_flush(fifo_flush), .ready_out(ready_out), .irq(irq));

  radio_supply_model #(.RAMP(5)) sup (.sys_clk(sys_clk), .reset(reset), .vreg_en(vreg_en),
    .vreg_ok_pin(vreg_ok));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic hang();
    n_mismatch++;
    $display("BAD %0t wait expired", $time);
    wrap_up();
  endtask : hang

  // Address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k <= 50; k++) begin
      if (k == 50) hang();
      @(posedge sys_clk);
      if (bvalid) begin
        resp = bresp;
        break;
      end
      if (awready && !ta) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !tw) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic ta;
    ta = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k <= 50; k++) begin
      if (k == 50) hang();
      @(posedge sys_clk);
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        break;
      end
      if (arready && !ta) begin
        ta = 1'b1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic wait_mode(input logic [3:0] m);
    for (int k = 0; k <= 100; k++) begin
      if (k == 100) hang();
      rd(`RPM_OFS_STATUS, st);
      if (st[8] === 1'b0 && st[7:4] === m) break;
    end
  endtask : wait_mode

  function automatic logic [8:0] dom_of(input logic [3:0] m);
    case (m)
      4'h5: return 9'h1c0;
      4'h6: return 9'h141;
      4'h8: return 9'h1e0;
      4'h9: return 9'h1e9;
      4'hb: return 9'h002;
      4'hc: return 9'h1f0;
      4'hd: return 9'h1f5;
      default: return 9'h000;
    endcase
  endfunction : dom_of

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset, sel_low, fifo_empty} = 3'b111;
    {awvalid, wvalid, bready, arvalid, rready, vio_low} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(`RPM_OFS_MODE, st);
    chk(st, 32'h0);
    chk(dom, 9'h000);
    // Transmit then receive session, then FIFO and wake-on-radio
    for (int i = 0; i < 11; i++) begin
      fifo_empty <= (i != 7);
      wr(`RPM_OFS_MODE, {28'h0, seq[i]});
      if (i == 7) begin
        repeat (20) @(posedge sys_clk);
        rd(`RPM_OFS_STATUS, st);
        chk(st[8:4], 5'h19);
        fifo_empty <= 1'b1;
        for (int k = 0; k <= 20; k++) begin
          if (k == 20) hang();
          @(posedge sys_clk);
          if (fifo_flush === 1'b1) break;
        end
      end
      wait_mode(seq[i]);
      chk(dom, dom_of(seq[i]));
      if (dom[8]) chk(st[0], 1'b1);
      if (dom[8]) chk(vreg_en, 1'b1);
      if (seq[i] == 4'h5) repeat (30) @(posedge sys_clk);
    end
    rd(`RPM_OFS_IRQ_STAT, st);
    chk(st[2], 1'b1);
    chk(irq, 1'b0);
    wr(`RPM_OFS_IRQ_STAT, 32'hf);
    wr(`RPM_OFS_IRQ_MASK, 32'h7);
    wr(`RPM_OFS_MODE, 32'h2);
    rd(`RPM_OFS_STATUS, st);
    chk(st[7:4], 4'h0);
    rd(`RPM_OFS_IRQ_STAT, st);
    chk(st[3:0], 4'h8);
    chk(irq, 1'b0);
    wr(`RPM_OFS_IRQ_MASK, 32'hf);
    rd(`RPM_OFS_IRQ_MASK, st);
    chk(st, 32'hf);
    chk(irq, 1'b1);
    wr(`RPM_OFS_IRQ_STAT, 32'hf);
    rd(`RPM_OFS_IRQ_STAT, st);
    chk(st, 32'h0);
    chk(irq, 1'b0);
    vio_low <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(`RPM_OFS_STATUS, st);
    chk(st[1], 1'b1);
    chk(irq, 1'b1);
    wr(12'h010, 32'h1);
    chk(resp, 2'b10);
    rd(12'h010, st);
    chk(st, 32'h0);
    chk(resp, 2'b00);
    // Deep sleep loses state; select low wakes it
    wr(`RPM_OFS_MODE, 32'h1);
    for (int k = 0; k <= 20; k++) begin
      if (k == 20) hang();
      @(posedge sys_clk);
      if (ready_out === 1'b0) break;
    end
    repeat (2) @(posedge sys_clk);
    chk(dom, 9'h000);
    chk(irq, 1'b0);
    sel_low <= 1'b0;
    for (int k = 0; k <= 60; k++) begin
      if (k == 60) hang();
      @(posedge sys_clk);
      if (ready_out === 1'b1) break;
    end
    sel_low <= 1'b1;
    rd(`RPM_OFS_IRQ_MASK, st);
    chk(st, 32'h0);
    rd(`RPM_OFS_STATUS, st);
    chk(st[9:4], 6'h00);
    wrap_up();
  end
endmodule : radio_power_mode_control_tb

// *** verification/radio_supply_model.sv ***
// Purpose: Regulator side of the radio power-mode control
// Assumes: Supplies come good a fixed ramp after enable
// Notes:   Drops good at once when the enable falls
`timescale 1ns/1ps
module radio_supply_model #(
  parameter int RAMP = 5
)(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic vreg_en,
  output logic      vreg_ok_pin
);
  int unsigned cnt;
  always_ff @(posedge sys_clk) begin
    if (reset || !vreg_en) begin
      cnt         <= 0;
      vreg_ok_pin <= 1'b0;
    end else if (cnt < RAMP) begin
      cnt <= cnt + 1;
    end else begin
      vreg_ok_pin <= 1'b1;
    end
  end
endmodule : radio_supply_model
